// ==== logic/adc_output_port_config_defines.vh ====
// constants for the converter result port configuration logic
`ifndef ADC_OUTPUT_PORT_CONFIG_DEFINES_VH
`define ADC_OUTPUT_PORT_CONFIG_DEFINES_VH

// system clock period, ns
`define CLK_PERIOD_NS      50
// result word width
`define RESULT_BITS        16
// result reset value
`define RESULT_RESET       16'h0000
// least internal serial clock periods per divider code, ns
`define SCLK_MIN_NS_DIV0   25
`define SCLK_MIN_NS_DIV1   50
`define SCLK_MIN_NS_DIV2   100
`define SCLK_MIN_NS_DIV3   200
// divider code used where the divider lines are ignored
`define DIVIDER_DEFAULT    2'h0
// longest gap between conversion starts in fastest mode, ns
`define FAST_MAX_GAP_NS    1000000
// gap in whole clock cycles, rounded down
`define FAST_MAX_GAP_CYC   (`FAST_MAX_GAP_NS / `CLK_PERIOD_NS)
// byte lane positions on the result bus
`define LOW_BYTE_LSB       0
`define HIGH_BYTE_LSB      8
// divider lines on the result bus
`define DIVIDER_LSB        2

`endif

// ==== logic/adc_output_port_config.v ====
// result port of the converter: byte order, coding, mode decode, parallel or serial output
`timescale 1ns/1ps
`include "adc_output_port_config_defines.vh"

module adc_output_port_config #(
	parameter FAST_MAX_GAP_CYC = `FAST_MAX_GAP_CYC
) (
	input  wire        clock,
	input  wire        resetn,
	input  wire [15:0] conversion_result,
	input  wire        result_valid,
	input  wire        conversion_start,
	input  wire        byte_order_select,
	input  wire        output_coding_select,
	input  wire        fast_mode_select,
	input  wire        low_power_select,
	input  wire        port_type_select,
	input  wire        clock_source_select,
	input  wire        read_timing_select,
	input  wire [15:0] data_bus_in,
	input  wire        serial_clock_in,
	output reg  [15:0] data_bus_out,
	output reg  [15:0] data_bus_oe,
	output reg         serial_clock_out,
	output reg         serial_clock_oe,
	output reg         serial_result_out,
	output reg         serial_frame,
	output reg         mode_fast,
	output reg         mode_normal,
	output reg         mode_low_power,
	output reg         fast_rate_violation
);

	localparam ST_IDLE  = 2'b01;
	localparam ST_SHIFT = 2'b10;

	reg  [1:0]  state;
	reg  [15:0] last_result;
	reg  [15:0] shift_word;
	reg  [4:0]  bits_left;
	reg  [3:0]  half_count;
	reg  [3:0]  half_limit;
	reg         ext_clock_prev;
	reg  [31:0] gap_count;
	wire [15:0] coded;
	wire        internal_clock;
	wire        after_convert;
	wire        start_frame;
	wire        ext_rise;
	wire [1:0]  divider;
	wire        during_convert;
	wire [15:0] frame_word;
	wire        half_done;
	wire        clock_fall;
	wire        bit_advance;
	wire        frame_end;
	wire        late_start;
	wire [15:0] next_data_bus_oe;
	reg         next_mode_fast;
	reg         next_mode_normal;
	reg         next_mode_low_power;
	genvar      lane_index;

	// result coding: straight binary or msb inverted
	function [15:0] code_word;
		input [15:0] word;
		input        straight;
		begin
			if (straight) begin
				code_word = word;
			end else begin
				code_word = {~word[15], word[14:0]};
			end
		end
	endfunction

	// half period of internal serial clock in cycles, rounded up, never below one
	function [3:0] half_cycles;
		input [1:0] div;
		integer ns;
		integer cyc;
		begin
			ns = `SCLK_MIN_NS_DIV0;
			case (div)
				2'h0: ns = `SCLK_MIN_NS_DIV0;
				2'h1: ns = `SCLK_MIN_NS_DIV1;
				2'h2: ns = `SCLK_MIN_NS_DIV2;
				default: ns = `SCLK_MIN_NS_DIV3;
			endcase
			cyc = (ns + 2 * `CLK_PERIOD_NS - 1) / (2 * `CLK_PERIOD_NS);
			if (cyc < 1) begin
				cyc = 1;
			end
			half_cycles = cyc[3:0];
		end
	endfunction

	// drive enable of one bus lane; serial mode turns lanes into port pins or inputs
	function lane_driven;
		input integer lane;
		input         serial;
		begin
			if (!serial) begin
				lane_driven = 1'b1;
			end else if (lane < 2) begin
				lane_driven = 1'b0;
			end else if (lane < 4) begin
				lane_driven = 1'b0;
			end else begin
				lane_driven = 1'b0;
			end
		end
	endfunction

	assign coded          = code_word(conversion_result, output_coding_select);
	assign internal_clock = ~clock_source_select;
	assign after_convert  = internal_clock & ~read_timing_select;
	// divider lines only read in internal read-after-convert
	assign divider = after_convert ? data_bus_in[`DIVIDER_LSB+1:`DIVIDER_LSB]
	                               : `DIVIDER_DEFAULT;
	// frame start: during-convert sends previous result at conversion start
	assign during_convert = internal_clock & read_timing_select;
	assign start_frame    = during_convert ? conversion_start : result_valid;
	assign frame_word     = during_convert ? last_result : coded;
	assign ext_rise       = serial_clock_in & ~ext_clock_prev;

	// bit steps: falling edge of the internal clock or a sampled external rise
	assign half_done   = (half_count == half_limit - 4'h1);
	assign clock_fall  = half_done & serial_clock_out;
	assign bit_advance = internal_clock ? clock_fall : ext_rise;
	assign frame_end   = (bits_left == 5'h00) | ~port_type_select;
	// a start that comes only after the limit still counts as late
	assign late_start  = conversion_start & (gap_count >= FAST_MAX_GAP_CYC);

	// per-lane drive enables for the result bus
	generate
		for (lane_index = 0; lane_index < 16; lane_index = lane_index + 1) begin : lane_enable
			assign next_data_bus_oe[lane_index] = lane_driven(lane_index, port_type_select);
		end
	endgenerate

	// conversion mode from the two straps; both high leaves no mode selected
	always @* begin
		next_mode_fast      = 1'b0;
		next_mode_normal    = 1'b0;
		next_mode_low_power = 1'b0;
		case ({fast_mode_select, low_power_select})
			2'b10: begin
				next_mode_fast = 1'b1;
			end
			2'b01: begin
				next_mode_low_power = 1'b1;
			end
			2'b00: begin
				next_mode_normal = 1'b1;
			end
			default: begin
				next_mode_normal = 1'b0;
			end
		endcase
	end

	// conversion mode register
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mode_fast      <= 1'b0;
			mode_normal    <= 1'b1;
			mode_low_power <= 1'b0;
		end else begin
			mode_fast      <= next_mode_fast;
			mode_low_power <= next_mode_low_power;
			mode_normal    <= next_mode_normal;
		end
	end

	// watch start spacing in fastest mode only
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			gap_count           <= 32'h00000000;
			fast_rate_violation <= 1'b0;
		end else if (!mode_fast) begin
			gap_count           <= 32'h00000000;
			fast_rate_violation <= 1'b0;
		end else if (conversion_start) begin
			// a late start sets the flag rather than clearing it
			gap_count           <= 32'h00000000;
			fast_rate_violation <= late_start;
		end else if (gap_count >= FAST_MAX_GAP_CYC) begin
			fast_rate_violation <= 1'b1;
		end else begin
			gap_count <= gap_count + 32'h00000001;
		end
	end

	// parallel bus: byte order and drive enables
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			data_bus_out <= `RESULT_RESET;
			data_bus_oe  <= 16'h0000;
			last_result  <= `RESULT_RESET;
		end else begin
			if (result_valid) begin
				last_result <= coded;
				if (byte_order_select) begin
					data_bus_out <= {coded[7:0], coded[15:8]};
				end else begin
					data_bus_out <= coded;
				end
			end
			// serial mode releases bits 1-0 and turns 2-3 into inputs
			data_bus_oe <= next_data_bus_oe;
		end
	end

	// external clock edge tracking and serial clock drive enable
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ext_clock_prev  <= 1'b0;
			serial_clock_oe <= 1'b0;
		end else begin
			ext_clock_prev  <= serial_clock_in;
			serial_clock_oe <= port_type_select & internal_clock;
		end
	end

	// internal serial clock: idles low, toggles each half period inside a frame
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			half_count       <= 4'h0;
			serial_clock_out <= 1'b0;
		end else if (state != ST_SHIFT || frame_end) begin
			half_count       <= 4'h0;
			serial_clock_out <= 1'b0;
		end else if (internal_clock) begin
			if (half_done) begin
				half_count       <= 4'h0;
				serial_clock_out <= ~serial_clock_out;
			end else begin
				half_count <= half_count + 4'h1;
			end
		end
	end

	// serial shifter, msb first, one bit per step
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state             <= ST_IDLE;
			shift_word        <= `RESULT_RESET;
			bits_left         <= 5'h00;
			half_limit        <= 4'h1;
			serial_result_out <= 1'b0;
			serial_frame      <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (port_type_select && start_frame) begin
						shift_word        <= {frame_word[14:0], 1'b0};
						serial_result_out <= frame_word[15];
						bits_left         <= 5'h10;
						half_limit        <= half_cycles(divider);
						serial_frame      <= 1'b1;
						state             <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (bit_advance) begin
						bits_left         <= bits_left - 5'h01;
						serial_result_out <= shift_word[15];
						shift_word        <= {shift_word[14:0], 1'b0};
					end
					if (frame_end) begin
						serial_frame <= 1'b0;
						state        <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// ==== tb/adc_output_port_config_props.sv ====
// checker for the result port configuration block
`timescale 1ns/1ps
module adc_output_port_config_props #(
	parameter FAST_MAX_GAP_CYC = 20000
) (
	input wire        clock,
	input wire        resetn,
	input wire [15:0] conversion_result,
	input wire        result_valid,
	input wire        conversion_start,
	input wire        byte_order_select,
	input wire        output_coding_select,
	input wire        fast_mode_select,
	input wire        low_power_select,
	input wire        port_type_select,
	input wire        clock_source_select,
	input wire [15:0] data_bus_out,
	input wire [15:0] data_bus_oe,
	input wire        serial_clock_oe,
	input wire        serial_frame,
	input wire        mode_fast,
	input wire        mode_low_power,
	input wire        fast_rate_violation
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// cycles since the last start while in fastest mode
	int gap;
	always @(posedge clock or negedge resetn)
		if (!resetn) gap <= 0;
		else gap <= (conversion_start || !fast_mode_select || low_power_select) ? 0 : gap + 1;
	AST_STRAIGHT: assert property (result_valid && output_coding_select && !byte_order_select
		##1 !result_valid |-> ##1 data_bus_out == $past(conversion_result, 2)) else $error("plain order wrong");
	AST_SWAP: assert property (result_valid && output_coding_select && byte_order_select
		##1 !result_valid |-> ##1 data_bus_out == {$past(conversion_result[7:0], 2),
		$past(conversion_result[15:8], 2)}) else $error("swapped order wrong");
	AST_TWOS: assert property (result_valid && !output_coding_select && !byte_order_select
		##1 !result_valid |-> ##1 data_bus_out == ($past(conversion_result, 2) ^ 16'h8000))
		else $error("twos complement coding wrong");
	AST_FAST: assert property (fast_mode_select && !low_power_select |=> mode_fast) else $error("fast mode missing");
	AST_LOWP: assert property (low_power_select && !fast_mode_select |=> mode_low_power && !mode_fast)
		else $error("low power mode missing");
	AST_NOVIOL: assert property (!fast_mode_select |-> ##2 !fast_rate_violation) else $error("rate flag outside fast");
	AST_GAP: assert property (gap > FAST_MAX_GAP_CYC + 1 |-> fast_rate_violation) else $error("rate flag missing");
	AST_PAR_OE: assert property (!port_type_select |=> data_bus_oe == 16'hFFFF) else $error("parallel not driven");
	AST_SER_OE: assert property (port_type_select |=> data_bus_oe[1:0] == 2'h0) else $error("bits 0,1 driven");
	AST_SCLK_OE: assert property (port_type_select && !clock_source_select |=> serial_clock_oe)
		else $error("serial clock not driven");
	// main scenarios
	cover property (serial_frame ##1 !serial_frame);
	cover property (fast_rate_violation);
	cover property (result_valid && byte_order_select);
endmodule
bind adc_output_port_config adc_output_port_config_props #(.FAST_MAX_GAP_CYC(FAST_MAX_GAP_CYC)) props (.*);

// ==== tb/host_reader.sv ====
// host model clocking a word out of the serial port
`timescale 1ns/1ps
module host_reader (
	input wire        clock,
	input wire        serial_frame,
	input wire        serial_result_out,
	input wire        serial_clock_out,
	input wire        serial_clock_oe,
	output reg        serial_clock_in,
	output reg [15:0] word_seen
);
	reg [2:0] tick;
	reg [4:0] bits;
	reg       frame_prev;
	reg       clock_out_prev;
	initial begin
		serial_clock_in = 0;
		tick = 0;
		bits = 0;
		word_seen = 0;
		frame_prev = 0;
		clock_out_prev = 0;
	end
	// word cleared at frame start; port clock: bit taken at each rise;
	// own slow clock only within frames while the port leaves the line alone
	always @(negedge clock) begin
		frame_prev <= serial_frame;
		clock_out_prev <= serial_clock_out;
		if (!serial_frame) begin
			serial_clock_in <= 0;
			tick <= 0;
			bits <= 0;
		end else if (!frame_prev) begin
			word_seen <= 16'h0000;
			tick <= tick + 1;
		end else if (serial_clock_oe) begin
			if (serial_clock_out && !clock_out_prev && bits < 16) begin
				word_seen <= {word_seen[14:0], serial_result_out};
				bits <= bits + 1;
			end
		end else begin
			tick <= tick + 1;
			if (tick == 3 && bits < 16) begin
				word_seen <= {word_seen[14:0], serial_result_out};
				bits <= bits + 1;
				serial_clock_in <= 1;
			end
			if (tick == 7) serial_clock_in <= 0;
		end
	end
endmodule

// ==== tb/tb_adc_output_port_config.sv ====
// self-checking bench for the result port configuration block
`timescale 1ns/1ps
`define CHK(n,e,s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module tb_adc_output_port_config;
	reg        clock = 0, resetn = 0, result_valid = 0, conversion_start = 0;
	reg        byte_order_select = 0, output_coding_select = 1, read_timing_select = 0;
	reg        fast_mode_select = 0, low_power_select = 0, port_type_select = 0;
	reg        clock_source_select = 0;
	reg [15:0] conversion_result = 16'h0000, data_bus_in = 16'h0000, e;
	wire [15:0] data_bus_out, data_bus_oe, word_seen;
	wire       serial_clock_in, serial_clock_out, serial_clock_oe, serial_result_out, serial_frame;
	wire       mode_fast, mode_normal, mode_low_power, fast_rate_violation;
	integer    num_errors = 0, total_checks = 0, n, i, len;
	always #25 clock = ~clock;
	adc_output_port_config #(.FAST_MAX_GAP_CYC(20)) dut (.*);
	host_reader model (.clock, .serial_frame, .serial_result_out, .serial_clock_out,
		.serial_clock_oe, .serial_clock_in, .word_seen);
	// one result plus conversion start, one cycle long
	task fire(input [15:0] v);
		begin
			@(negedge clock);
			conversion_result = v;
			result_valid = 1;
			conversion_start = 1;
			@(negedge clock);
			result_valid = 0;
			conversion_start = 0;
		end
	endtask
	// count cycles of one serial frame
	task wait_frame;
		begin
			len = 0;
			for (n = 0; !serial_frame && n < 100; n++) @(negedge clock);
			while (serial_frame && len < 400) begin
				@(negedge clock);
				len++;
			end
		end
	endtask
	task close_out;
		begin
			if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	// main sequence, straps changed only between conversions
	initial begin
		repeat (6) @(negedge clock);
		resetn = 1;
		for (i = 0; i < 4; i++) begin
			byte_order_select = i[0];
			output_coding_select = i[1];
			fire(16'h12F4);
			@(negedge clock);
			e = i[1] ? 16'h12F4 : 16'h92F4;
			e = i[0] ? {e[7:0], e[15:8]} : e;
			`CHK("parallel word", e, data_bus_out)
			`CHK("parallel enable", 16'hFFFF, data_bus_oe)
		end
		for (i = 0; i < 3; i++) begin
			{fast_mode_select, low_power_select} = i[1:0];
			repeat (2) @(negedge clock);
			e[2:0] = (i == 0) ? 3'h2 : (i == 1) ? 3'h1 : 3'h4;
			`CHK("mode", e[2:0], {mode_fast, mode_normal, mode_low_power})
		end
		repeat (4) fire(16'h0001);
		`CHK("rate flag kept low", 1'h0, fast_rate_violation)
		repeat (25) @(negedge clock);
		`CHK("rate flag", 1'h1, fast_rate_violation)
		fast_mode_select = 0;
		repeat (2) @(negedge clock);
		`CHK("rate flag normal", 1'h0, fast_rate_violation)
		{port_type_select, clock_source_select, output_coding_select, byte_order_select} = 4'hC;
		@(negedge clock);
		`CHK("serial enable", 16'h0000, data_bus_oe)
		fire(16'hA5C3);
		wait_frame;
		`CHK("serial word", 16'h25C3, word_seen)
		clock_source_select = 0;
		data_bus_in = 16'h000C;
		for (i = 0; i < 2; i++) begin
			read_timing_select = i[0];
			fire(i ? 16'h5678 : 16'h1234);
			wait_frame;
			`CHK("frame length", i ? 33 : 65, len)
			`CHK("serial word internal", 16'h9234, word_seen)
		end
		close_out;
	end
	// hang guard
	initial begin
		#(50 * 4000);
		num_errors++;
		close_out;
	end
endmodule
